// File: logic/branch_decode_if.sv
// Coprocessor handshake between host and translation unit.
// Assumes one shared clock; unit answers one cycle after a request.
`timescale 1ns/1ps
`default_nettype none
interface branch_decode_if;
   import branch_decode_pkg::*;
   logic        req;
   logic        supervisor;
   logic [5:0]  condition_selector;
   logic [15:0] op_word;
   logic [5:0]  ea_field;
   logic        ack;
   directive_t  directive;
   logic        op_ok;
   logic        long_disp;
   ea_class_t   ea_class;
   modport host (output req, supervisor, condition_selector, op_word,
                 ea_field, input ack, directive, op_ok, long_disp,
                 ea_class);
   modport unit (input req, supervisor, condition_selector, op_word,
                 ea_field, output ack, directive, op_ok, long_disp,
                 ea_class);
endinterface : branch_decode_if
`default_nettype wire

// File: logic/branch_decode_pkg.sv
// Shared constants and types for the branch and address-mode decoder.
// Assumes both ends include it through a wildcard import.
package branch_decode_pkg;
   localparam logic [2:0] EA_MODE_DREG    = 3'h0;
   localparam logic [2:0] EA_MODE_AREG    = 3'h1;
   localparam logic [2:0] EA_MODE_IND     = 3'h2;
   localparam logic [2:0] EA_MODE_POSTINC = 3'h3;
   localparam logic [2:0] EA_MODE_PREDEC  = 3'h4;
   localparam logic [2:0] EA_MODE_DISP    = 3'h5;
   localparam logic [2:0] EA_MODE_INDEX   = 3'h6;
   localparam logic [2:0] EA_MODE_EXT     = 3'h7;
   localparam logic [2:0] EA_EXT_ABS_W    = 3'h0;
   localparam logic [2:0] EA_EXT_ABS_L    = 3'h1;
   localparam logic [2:0] EA_EXT_PC_D     = 3'h2;
   localparam logic [2:0] EA_EXT_PC_X     = 3'h3;
   localparam logic [2:0] EA_EXT_IMM      = 3'h4;
   localparam logic [8:0] BRANCH_PATTERN  = 9'h1E1;
   localparam int         OPW_PAT_HI      = 15;
   localparam int         OPW_PAT_LO      = 7;
   localparam int         OPW_SIZE_BIT    = 6;
   localparam int         COND_W          = 6;
   localparam logic [5:0] COND_LAST       = 6'h0F;
   localparam logic [7:0] STATUS_RESET    = 8'h00;
   localparam logic [15:0] COUNT_END      = 16'hFFFF;

   // Category flags of one address mode
   typedef struct packed {
      logic data;
      logic memory;
      logic control;
      logic alterable;
      logic valid;
   } ea_class_t;

   // Directive returned by the unit
   typedef enum logic [2:0] {
      DIR_NONE   = 3'b000,
      DIR_TAKE   = 3'b001,
      DIR_FALL   = 3'b010,
      DIR_TRAP   = 3'b100
   } directive_t;
endpackage : branch_decode_pkg

// File: logic/branch_host.sv
// Host end: issues branch requests and computes the new program counter.
// Assumes the unit answers with ack one cycle after req.
`timescale 1ns/1ps
`default_nettype none
module branch_host
   import branch_decode_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   branch_decode_if.host    bus,
   input  wire logic        start,
   input  wire logic        is_dbcc,
   input  wire logic        supervisor,
   input  wire logic [15:0] op_word,
   input  wire logic [5:0]  condition_selector,
   input  wire logic [5:0]  ea_field,
   input  wire logic [31:0] ext_addr,
   input  wire logic [15:0] disp_hi,
   input  wire logic [15:0] disp_lo,
   input  wire logic [31:0] next_pc,
   input  wire logic [15:0] counter_in,
   output logic             busy,
   output logic             done,
   output logic             trap,
   output logic [31:0]      pc_out,
   output logic [15:0]      counter_data_register
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } state_t;

   state_t      state_q;
   logic        dbcc_q;
   logic        done_q;
   logic        trap_q;
   logic [31:0] pc_q;
   logic [15:0] cnt_q;
   logic [31:0] disp;
   logic [15:0] cnt_dec;

   // High word first, low word only in long branch form
   assign disp = (bus.long_disp && !dbcc_q) ?
                 {disp_hi, disp_lo} :
                 {{16{disp_hi[15]}}, disp_hi};
   assign cnt_dec = counter_in - 16'h0001;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= ST_IDLE;
         dbcc_q  <= 1'b0;
         done_q  <= 1'b0;
         trap_q  <= 1'b0;
         pc_q    <= 32'h0000_0000;
         cnt_q   <= 16'h0000;
      end else begin
         done_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (start) begin
                  dbcc_q  <= is_dbcc;
                  state_q <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (bus.ack) begin
                  done_q  <= 1'b1;
                  state_q <= ST_IDLE;
                  trap_q  <= (bus.directive == DIR_TRAP);
                  pc_q    <= next_pc;
                  if (bus.directive == DIR_TAKE && !dbcc_q) begin
                     pc_q <= ext_addr + disp;
                  end else if (bus.directive == DIR_FALL && dbcc_q) begin
                     cnt_q <= cnt_dec;
                     if (cnt_dec != COUNT_END) begin
                        pc_q <= ext_addr + disp;
                     end
                  end
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Request held while waiting for the answer
   assign bus.req                = (state_q == ST_WAIT) && !bus.ack;
   assign bus.supervisor         = supervisor;
   assign bus.condition_selector = condition_selector;
   assign bus.op_word            = op_word;
   assign bus.ea_field           = ea_field;
   assign busy                   = (state_q == ST_WAIT);
   assign done                   = done_q;
   assign trap                   = trap_q;
   assign pc_out                 = pc_q;
   assign counter_data_register  = cnt_q;
endmodule : branch_host
`default_nettype wire

// File: logic/paged_translation_unit.sv
// Unit end: decodes address-mode categories and branch conditions.
// Assumes host drives requests synchronously, holding them one cycle.
`timescale 1ns/1ps
`default_nettype none
module paged_translation_unit
   import branch_decode_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst_n,
   branch_decode_if.unit   bus,
   input  wire logic [7:0] status_set,
   input  wire logic [7:0] status_clr,
   output logic      [7:0] unit_status_register,
   output logic            mem_alterable,
   output logic            data_alterable,
   output logic            control_alterable
);
   logic [7:0] status_q;
   logic       ack_q;
   directive_t dir_q;
   logic       ok_q;
   logic       long_q;
   ea_class_t  cls_q;
   ea_class_t  cls_d;

   // Category table per mode and register
   function automatic ea_class_t classify(input logic [5:0] ea);
      ea_class_t c;
      c = '{default: 1'b0};
      c.valid = 1'b1;
      if (ea[5:3] == EA_MODE_DREG) begin
         c.data = 1'b1;
         c.alterable = 1'b1;
      end else if (ea[5:3] == EA_MODE_AREG) begin
         c.alterable = 1'b1;
      end else if (ea[5:3] == EA_MODE_POSTINC ||
                   ea[5:3] == EA_MODE_PREDEC) begin
         c.data = 1'b1;
         c.memory = 1'b1;
         c.alterable = 1'b1;
      end else if (ea[5:3] == EA_MODE_IND || ea[5:3] == EA_MODE_DISP ||
                   ea[5:3] == EA_MODE_INDEX) begin
         c.data = 1'b1;
         c.memory = 1'b1;
         c.control = 1'b1;
         c.alterable = 1'b1;
      end else if (ea[2:0] == EA_EXT_ABS_W || ea[2:0] == EA_EXT_ABS_L) begin
         c.data = 1'b1;
         c.memory = 1'b1;
         c.control = 1'b1;
         c.alterable = 1'b1;
      end else if (ea[2:0] == EA_EXT_PC_D || ea[2:0] == EA_EXT_PC_X) begin
         c.data = 1'b1;
         c.memory = 1'b1;
         c.control = 1'b1;
      end else if (ea[2:0] == EA_EXT_IMM) begin
         c.data = 1'b1;
         c.memory = 1'b1;
      end else begin
         c.valid = 1'b0;
      end
      return c;
   endfunction

   // Condition test over status flags
   function automatic logic cond_true(input logic [5:0] sel,
                                      input logic [7:0] flags);
      logic f;
      f = flags[sel[3:1]];
      return sel[0] ? ~f : f;
   endfunction

   assign cls_d = classify(bus.ea_field);

   // Status flags: set wins over clear; branch never writes them
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_q <= STATUS_RESET;
      end else begin
         status_q <= (status_q & ~status_clr) | status_set;
      end
   end

   // Answer to each request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_q  <= 1'b0;
         dir_q  <= DIR_NONE;
         ok_q   <= 1'b0;
         long_q <= 1'b0;
      end else begin
         ack_q <= bus.req;
         if (bus.req) begin
            ok_q   <= (bus.op_word[OPW_PAT_HI:OPW_PAT_LO] ==
                       BRANCH_PATTERN);
            long_q <= bus.op_word[OPW_SIZE_BIT];
            if (!bus.supervisor) begin
               dir_q <= DIR_TRAP;
            end else if (bus.condition_selector > COND_LAST) begin
               dir_q <= DIR_TRAP;
            end else if (cond_true(bus.condition_selector, status_q)) begin
               dir_q <= DIR_TAKE;
            end else begin
               dir_q <= DIR_FALL;
            end
         end
      end
   end

   // Address-mode category register
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cls_q <= '{default: 1'b0};
      end else if (bus.req) begin
         cls_q <= cls_d;
      end
   end

   assign bus.ack       = ack_q;
   assign bus.directive = dir_q;
   assign bus.op_ok     = ok_q;
   assign bus.long_disp = long_q;
   assign bus.ea_class  = cls_q;
   assign unit_status_register = status_q;
   assign mem_alterable     = cls_q.memory & cls_q.alterable;
   assign data_alterable    = cls_q.data & cls_q.alterable;
   assign control_alterable = cls_q.control & cls_q.alterable;
endmodule : paged_translation_unit
`default_nettype wire

// File: verification/branch_decode_sva.sv
// Checker for the host-unit handshake of the branch decoder.
// Assumes one clock; instantiated beside the interface.
`timescale 1ns/1ps
`default_nettype none
module branch_decode_sva
   import branch_decode_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        req,
   input wire logic        supervisor,
   input wire logic [5:0]  condition_selector,
   input wire logic [15:0] op_word,
   input wire logic [5:0]  ea_field,
   input wire logic        ack,
   input wire directive_t  directive,
   input wire logic        op_ok,
   input wire logic        long_disp,
   input wire ea_class_t   ea_class
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // Request taken by the unit
   sequence s_req;
      req && !ack;
   endsequence
   // Category flags one cycle after a request
   property p_cls(logic [5:0] m, logic [5:0] k, logic [3:0] c);
      s_req ##0 ((ea_field & k) == m) |=> ea_class[4:1] == c;
   endproperty
   a_ack_next: assert property (s_req |=> ack)
      else $error("ack missing after request");
   a_ack_once: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   a_user_trap: assert property (s_req ##0 !supervisor |=>
      directive == DIR_TRAP) else $error("no trap outside supervisor");
   a_undef_trap: assert property (s_req ##0 supervisor &&
      condition_selector > COND_LAST |=> directive == DIR_TRAP)
      else $error("no trap on undefined selector");
   a_legal_answer: assert property (s_req ##0 supervisor &&
      condition_selector <= COND_LAST |=> directive inside {DIR_TAKE,
      DIR_FALL}) else $error("bad directive");
   a_pattern_match: assert property (s_req |=> op_ok ==
      ($past(op_word[15:7]) == BRANCH_PATTERN)) else $error("op_ok wrong");
   a_size_bit: assert property (s_req |=>
      long_disp == $past(op_word[OPW_SIZE_BIT])) else $error("size wrong");
   a_postinc_class: assert property (p_cls(6'h18, 6'h38, 4'hD))
      else $error("postincrement class wrong");
   a_predec_class: assert property (p_cls(6'h20, 6'h38, 4'hD))
      else $error("predecrement class wrong");
   a_disp_class: assert property (p_cls(6'h28, 6'h38, 4'hF))
      else $error("displacement class wrong");
   a_pc_disp: assert property (p_cls(6'h3A, 6'h3F, 4'hE))
      else $error("pc displacement class wrong");
   a_pc_index: assert property (p_cls(6'h3B, 6'h3F, 4'hE))
      else $error("pc index class wrong");
endmodule // branch_decode_sva
`default_nettype wire

// File: verification/mmu_branch_and_ea_decoder_test.sv
// Bench driving host and unit ends joined by the interface.
// Assumes the package and both design ends are compiled first.
`timescale 1ns/1ps
`default_nettype none
module mmu_branch_and_ea_decoder_test;
   import branch_decode_pkg::*;
   logic        clk, rst_n, start, is_dbcc, sup, busy, done, trap;
   logic        m_alt, d_alt, c_alt, t;
   logic [15:0] opw, dhi, dlo, cnt_in, cnt;
   logic [5:0]  cond, ea;
   logic [31:0] pc;
   logic [7:0]  sset, sclr, sr, pat;
   logic [5:0]  eas [12] = '{6'h00, 6'h08, 6'h10, 6'h18, 6'h20, 6'h28,
                             6'h30, 6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3C};
   logic [3:0]  cls [12] = '{4'h9, 4'h1, 4'hF, 4'hD, 4'hD, 4'hF,
                             4'hF, 4'hF, 4'hF, 4'hE, 4'hE, 4'hC};
   int          n_errors, checks, cycles;
   branch_decode_if bus();
   paged_translation_unit u_paged_translation_unit (.clk(clk),
      .rst_n(rst_n), .bus(bus.unit), .status_set(sset), .status_clr(sclr),
      .unit_status_register(sr), .mem_alterable(m_alt),
      .data_alterable(d_alt), .control_alterable(c_alt));
   branch_host u_branch_host (.clk(clk), .rst_n(rst_n), .bus(bus.host),
      .start(start), .is_dbcc(is_dbcc), .supervisor(sup), .op_word(opw),
      .condition_selector(cond), .ea_field(ea), .ext_addr(32'h0000_1002),
      .disp_hi(dhi), .disp_lo(dlo), .next_pc(32'h0000_1006),
      .counter_in(cnt_in), .busy(busy), .done(done), .trap(trap),
      .pc_out(pc), .counter_data_register(cnt));
   branch_decode_sva u_branch_decode_sva (.clk(clk), .rst_n(rst_n),
      .req(bus.req), .supervisor(bus.supervisor),
      .condition_selector(bus.condition_selector), .op_word(bus.op_word),
      .ea_field(bus.ea_field), .ack(bus.ack), .directive(bus.directive),
      .op_ok(bus.op_ok), .long_disp(bus.long_disp),
      .ea_class(bus.ea_class));
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic print_verdict();
      $display("checks=%0d errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         print_verdict();
      end
   end
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic set_status(input logic [7:0] p);
      @(posedge clk);
      sset <= p;
      sclr <= ~p;
      @(posedge clk);
      sset <= 8'h00;
      sclr <= 8'h00;
   endtask
   task automatic run(input logic db, input logic s, input logic [15:0] w,
                      input logic [5:0] c, input logic [5:0] e,
                      input logic [15:0] n);
      int k;
      @(posedge clk);
      start <= 1'b1;
      is_dbcc <= db;
      sup <= s;
      opw <= w;
      cond <= c;
      ea <= e;
      cnt_in <= n;
      @(posedge clk);
      start <= 1'b0;
      #1;
      chk(busy, 1'b1);
      k = 0;
      while (done !== 1'b1 && k < 10) begin
         @(posedge clk);
         #1;
         k++;
      end
      chk(k, 2);
      chk({busy, done}, 2'b01);
   endtask
   initial begin
      {start, is_dbcc, sup, opw, cond, ea, cnt_in, sset, sclr} = '0;
      dhi = 16'hFFF0;
      dlo = 16'h0040;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         pat = i < 16 ? 8'hA5 : 8'h5A;
         if (i % 16 == 0) set_status(pat);
         t = pat[i[3:1]] ^ i[0];
         run(1'b0, 1'b1, {9'h1E1, i[4], i[5:0] & 6'h0F}, i[5:0] & 6'h0F,
             6'h10, 16'h0);
         chk(pc, !t ? 32'h1006 : i[4] ? 32'hFFF01042 :
             32'h0FF2);
         chk(bus.directive, t ? DIR_TAKE : DIR_FALL);
         chk(trap, 1'b0);
         chk(sr, pat);
      end
      $display("test branch conditions done");
      run(1'b0, 1'b0, 16'hF080, 6'h00, 6'h10, 16'h0);
      chk(trap, 1'b1);
      run(1'b0, 1'b1, 16'hF080, 6'h10, 6'h10, 16'h0);
      chk(trap, 1'b1);
      run(1'b0, 1'b1, 16'hF080, 6'h3F, 6'h10, 16'h0);
      chk({trap, bus.directive}, {1'b1, DIR_TRAP});
      $display("test traps done");
      for (int i = 0; i < 12; i++) begin
         run(1'b0, 1'b1, 16'hF080, 6'h00, eas[i], 16'h0);
         chk(bus.ea_class[4:1], cls[i]);
         chk(bus.ea_class[0], 1'b1);
         chk({m_alt, d_alt, c_alt}, {cls[i][2] & cls[i][0],
             cls[i][3] & cls[i][0], cls[i][1] & cls[i][0]});
      end
      run(1'b0, 1'b1, 16'hF080, 6'h00, 6'h3D, 16'h0);
      chk(bus.ea_class, 5'h00);
      $display("test address modes done");
      run(1'b1, 1'b1, 16'hF048, 6'h00, 6'h10, 16'h0005);
      chk({pc, cnt}, {32'h0FF2, 16'h0004});
      run(1'b1, 1'b1, 16'hF048, 6'h00, 6'h10, 16'h0000);
      chk({pc, cnt}, {32'h1006, 16'hFFFF});
      run(1'b1, 1'b1, 16'hF048, 6'h01, 6'h10, 16'h0009);
      chk({trap, pc, cnt}, {1'b0, 32'h1006, 16'hFFFF});
      run(1'b1, 1'b0, 16'hF048, 6'h01, 6'h10, 16'h0009);
      chk(trap, 1'b1);
      $display("test decrement branch done");
      print_verdict();
   end
endmodule // mmu_branch_and_ea_decoder_test
`default_nettype wire
